// File: core/gpps_top.sv
// Top of the general-purpose pin subsystem
// Notes on behaviour
// - Each pin has eight drive modes, from input only to weak both.
// - Each pin input selects CMOS or low-voltage TTL threshold.
// - Input and output disables per pin, set independently.
// - Hold mode freezes pad state so pins keep driving in deep sleep.
// - Output slew rate selectable per pin.
// - Pins forced disabled during power-on and any reset.
// - Per-pin matrix picks which internal signal drives or observes the pin.
// - Fixed-function pins bypass the general matrix.
// - Output register holds driven values; pin-state register returns real levels.
// - Configuration written by software through per-port register sets.
// - A pin raises an interrupt only when enabled.
// - Each port merges its pin interrupts into one request line.
// - In deep sleep ports either retain state or stay operational, per config.
// - Deep sleep ended by reset sends all pins to high impedance.
// - Deep sleep ended by interrupt keeps pins held until firmware releases them with unfreeze.
// - Nineteen pins; serial bus and debug pins usable as general pins.
`timescale 1ns/1ps
module gpps_top
  import gpps_pkg::*;
#(
  parameter int NPINS = GPPS_NUM_PINS,
  parameter int NSRC = 8
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic cfg_we, // Configuration write strobe
  input wire logic [1:0] cfg_port, // Port addressed by the write
  input wire logic [GPPS_PORT_W-1:0] cfg_pin_mask, // Pins of that port written
  input wire gpps_cfg_type cfg_data, // Configuration written
  input wire logic out_we, // Output data write strobe
  input wire logic [NPINS-1:0] out_data, // Output data written
  input wire logic [NPINS-1:0] irq_clr, // Interrupt flag clear, one per pin
  input wire logic [NSRC*NPINS-1:0] periph_out, // Peripheral outputs, NSRC per pin
  input wire logic [NPINS-1:0] fixed_en, // Pin owned by a fixed-function block
  input wire logic [NPINS-1:0] fixed_out, // Fixed-function output data
  input wire logic sleep_req, // Enter deep sleep
  input wire logic sleep_retain, // Retain pins in deep sleep, else keep running
  input wire logic wake_irq, // Wake by interrupt event
  input wire logic wake_rst, // Wake by reset
  input wire logic unfreeze, // Firmware releases retained pins
  input wire logic [NPINS-1:0] pad_in, // Pin levels
  output gpps_pad_type [NPINS-1:0] pad_ctl, // Pad driver controls
  output logic [NPINS-1:0] out_reg, // Output data register
  output logic [NPINS-1:0] pin_state, // Pin state register
  output logic [NPINS-1:0] periph_in, // Input seen by the selected peripheral
  output logic [NPINS-1:0] irq_flags, // Sticky pin flags
  output logic [GPPS_NUM_PORTS-1:0] port_irq, // One request per port
  output logic frozen // Pins retained
);

  // ----------------------------------------------------------------
  // Port layout: pins 0..7 port 0, 8..15 port 1, rest port 2
  // ----------------------------------------------------------------
  function automatic int port_of(input int p);
    return p / GPPS_PORT_W;
  endfunction

  typedef enum logic [1:0] {
    GPPS_ST_ACTIVE,
    GPPS_ST_SLEEP_RUN,
    GPPS_ST_SLEEP_HOLD,
    GPPS_ST_RETAIN
  } gpps_state_type;

  gpps_state_type state_r;
  gpps_cfg_type cfg_r [NPINS];
  logic [NPINS-1:0] out_r;
  logic [NPINS-1:0] dout;
  logic [NPINS-1:0] level;
  logic hold;
  logic force_off;
  logic [GPPS_PORT_W*GPPS_NUM_PORTS-1:0] lvl_ext;
  logic [GPPS_PORT_W*GPPS_NUM_PORTS-1:0] clr_ext;
  logic [GPPS_PORT_W*GPPS_NUM_PORTS-1:0] flag_ext;
  logic [2*GPPS_PORT_W*GPPS_NUM_PORTS-1:0] edge_ext;
  logic [GPPS_NUM_PORTS-1:0] irq_w;
  logic force_r;

  // ----------------------------------------------------------------
  // Per-port configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    for (int p = 0; p < NPINS; p++) begin
      if (!nrst) begin
        cfg_r[p] <= '{mode: GPPS_DM_DISABLE, default: '0};
      end else if (cfg_we && (cfg_port == 2'(port_of(p))) && cfg_pin_mask[p % GPPS_PORT_W]) begin
        cfg_r[p] <= cfg_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      out_r <= GPPS_RST_ZERO;
    end else if (out_we) begin
      out_r <= out_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      out_reg <= GPPS_RST_ZERO;
    end else begin
      out_reg <= out_r;
    end
  end

  // ----------------------------------------------------------------
  // Signal matrix
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      if (fixed_en[p]) begin
        dout[p] = fixed_out[p];
      end else if (cfg_r[p].sel == GPPS_SEL_FW) begin
        dout[p] = out_r[p];
      end else begin
        dout[p] = periph_out[p*NSRC + int'(cfg_r[p].sel)];
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int p = 0; p < NPINS; p++) begin
      if (!nrst) begin
        periph_in[p] <= 1'b0;
      end else begin
        periph_in[p] <= (!fixed_en[p] && cfg_r[p].sel != GPPS_SEL_FW) ? level[p] : 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Deep sleep retention
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r <= GPPS_ST_ACTIVE;
    end else begin
      case (state_r)
        GPPS_ST_ACTIVE: begin
          if (sleep_req) begin
            state_r <= sleep_retain ? GPPS_ST_SLEEP_HOLD : GPPS_ST_SLEEP_RUN;
          end
        end
        GPPS_ST_SLEEP_RUN: begin
          if (wake_rst || wake_irq) begin
            state_r <= GPPS_ST_ACTIVE;
          end
        end
        GPPS_ST_SLEEP_HOLD: begin
          if (wake_rst) begin
            state_r <= GPPS_ST_ACTIVE;
          end else if (wake_irq) begin
            state_r <= GPPS_ST_RETAIN;
          end
        end
        GPPS_ST_RETAIN: begin
          if (unfreeze) begin
            state_r <= GPPS_ST_ACTIVE;
          end
        end
        default: state_r <= GPPS_ST_ACTIVE;
      endcase
    end
  end

  assign hold = (state_r == GPPS_ST_SLEEP_HOLD) || (state_r == GPPS_ST_RETAIN);

  // Reset wake from any sleep drops the pads to high impedance
  always_ff @(posedge clock) begin
    if (!nrst) begin
      force_r <= 1'b1;
    end else begin
      force_r <= wake_rst && (state_r != GPPS_ST_ACTIVE);
    end
  end

  assign force_off = force_r;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      frozen <= 1'b0;
    end else begin
      frozen <= hold;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    gpps_pin u_pin (
      .clock(clock),
      .nrst(nrst),
      .cfg(cfg_r[g]),
      .dout(dout[g]),
      .hold(hold),
      .force_off(force_off),
      .pad_in(pad_in[g]),
      .pad_r(pad_ctl[g]),
      .level_r(level[g])
    );
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pin_state <= GPPS_RST_ZERO;
    end else begin
      pin_state <= level;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts, one block per port
  // ----------------------------------------------------------------
  always_comb begin
    lvl_ext = '0;
    clr_ext = '0;
    edge_ext = '0;
    for (int p = 0; p < NPINS; p++) begin
      lvl_ext[p] = level[p];
      clr_ext[p] = irq_clr[p];
      edge_ext[2*p +: 2] = cfg_r[p].edge_sel;
    end
  end

  for (genvar q = 0; q < GPPS_NUM_PORTS; q++) begin : g_port
    gpps_port_irq #(
      .WIDTH(GPPS_PORT_W)
    ) u_irq (
      .clock(clock),
      .nrst(nrst),
      .level(lvl_ext[q*GPPS_PORT_W +: GPPS_PORT_W]),
      .edge_sel(edge_ext[2*q*GPPS_PORT_W +: 2*GPPS_PORT_W]),
      .clr(clr_ext[q*GPPS_PORT_W +: GPPS_PORT_W]),
      .flag_r(flag_ext[q*GPPS_PORT_W +: GPPS_PORT_W]),
      .irq_r(irq_w[q])
    );
  end

  assign irq_flags = flag_ext[NPINS-1:0];
  assign port_irq = irq_w;

endmodule // gpps_top

// File: include/gpps_pkg.sv
// Package: constants and types for the general-purpose pin subsystem
package gpps_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int GPPS_NUM_PINS = 19;
  localparam int GPPS_NUM_PORTS = 3;
  localparam int GPPS_PORT_W = 8;
  localparam int GPPS_SEL_W = 3;
  localparam int GPPS_MODE_W = 3;

  // ----------------------------------------------------------------
  // Drive modes, one code per mode
  // ----------------------------------------------------------------
  typedef enum logic [GPPS_MODE_W-1:0] {
    GPPS_DM_OFF_IN  = 3'h0,
    GPPS_DM_WU_SD   = 3'h1,
    GPPS_DM_SU_WD   = 3'h2,
    GPPS_DM_OD_LO   = 3'h3,
    GPPS_DM_OD_HI   = 3'h4,
    GPPS_DM_STRONG  = 3'h5,
    GPPS_DM_DISABLE = 3'h6,
    GPPS_DM_WEAK    = 3'h7
  } gpps_mode_type;

  // Slew settings
  localparam logic GPPS_SLEW_FAST = 1'h0;
  localparam logic GPPS_SLEW_SLOW = 1'h1;

  // Threshold types
  localparam logic GPPS_VT_CMOS = 1'h0;
  localparam logic GPPS_VT_LVTTL = 1'h1;

  // Interrupt edge select codes
  localparam logic [1:0] GPPS_EDGE_OFF = 2'h0;
  localparam logic [1:0] GPPS_EDGE_RISE = 2'h1;
  localparam logic [1:0] GPPS_EDGE_FALL = 2'h2;
  localparam logic [1:0] GPPS_EDGE_BOTH = 2'h3;

  // Matrix source zero is the firmware output register
  localparam logic [GPPS_SEL_W-1:0] GPPS_SEL_FW = 3'h0;

  // Reset values
  localparam logic [GPPS_NUM_PINS-1:0] GPPS_RST_ZERO = 19'h0_0000;

  // Per-pin configuration
  typedef struct packed {
    gpps_mode_type mode;
    logic vtrip;
    logic slew;
    logic in_dis;
    logic out_dis;
    logic [1:0] edge_sel;
    logic [GPPS_SEL_W-1:0] sel;
  } gpps_cfg_type;

  // Per-pin analog-side drive controls
  typedef struct packed {
    logic strong_up;
    logic strong_dn;
    logic weak_up;
    logic weak_dn;
    logic in_en;
    logic vtrip;
    logic slew;
  } gpps_pad_type;

  // Decode the drive mode and data bit into pad driver enables
  function automatic logic [3:0] gpps_drive(input gpps_mode_type m, input logic d);
    logic [3:0] r;
    r = 4'h0;
    case (m)
      GPPS_DM_WU_SD: r = d ? 4'b0010 : 4'b0100;
      GPPS_DM_SU_WD: r = d ? 4'b1000 : 4'b0001;
      GPPS_DM_OD_LO: r = d ? 4'b0000 : 4'b0100;
      GPPS_DM_OD_HI: r = d ? 4'b1000 : 4'b0000;
      GPPS_DM_STRONG: r = d ? 4'b1000 : 4'b0100;
      GPPS_DM_WEAK: r = d ? 4'b0010 : 4'b0001;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

endpackage

// File: core/gpps_pin.sv
// Single pin: drive decode, hold latch and input sampling
`timescale 1ns/1ps
module gpps_pin
  import gpps_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire gpps_cfg_type cfg, // Pin configuration
  input wire logic dout, // Routed output data
  input wire logic hold, // Freeze pad controls
  input wire logic force_off, // Force disabled state
  input wire logic pad_in, // Level seen at the pad
  output gpps_pad_type pad_r, // Pad controls
  output logic level_r // Sampled pin level
);

  logic [3:0] drv;

  always_comb begin
    drv = gpps_drive(cfg.mode, dout);
    if (cfg.out_dis) begin
      drv = 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Pad controls; hold keeps the last state
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst || force_off) begin
      pad_r <= '0;
    end else if (!hold) begin
      pad_r.strong_up <= drv[3];
      pad_r.strong_dn <= drv[2];
      pad_r.weak_up <= drv[1];
      pad_r.weak_dn <= drv[0];
      pad_r.in_en <= !cfg.in_dis && (cfg.mode != GPPS_DM_DISABLE);
      pad_r.vtrip <= cfg.vtrip;
      pad_r.slew <= cfg.slew;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      level_r <= 1'b0;
    end else begin
      level_r <= pad_r.in_en ? pad_in : 1'b0;
    end
  end

endmodule // gpps_pin

// File: core/gpps_port_irq.sv
// Per-port interrupt flags and request
`timescale 1ns/1ps
module gpps_port_irq
  import gpps_pkg::*;
#(
  parameter int WIDTH = GPPS_PORT_W
) (
  input wire logic clock, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] level, // Sampled pin levels
  input wire logic [2*WIDTH-1:0] edge_sel, // Edge select per pin
  input wire logic [WIDTH-1:0] clr, // Flag clear strobes
  output logic [WIDTH-1:0] flag_r, // Sticky flags
  output logic irq_r // Port request
);

  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] hit;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      case (edge_sel[2*i +: 2])
        GPPS_EDGE_RISE: hit[i] = level[i] && !prev_r[i];
        GPPS_EDGE_FALL: hit[i] = !level[i] && prev_r[i];
        GPPS_EDGE_BOTH: hit[i] = level[i] ^ prev_r[i];
        default: hit[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      prev_r <= '0;
    end else begin
      prev_r <= level;
    end
  end

  // Set wins over clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_r <= '0;
    end else begin
      flag_r <= (flag_r & ~clr) | hit;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |((flag_r & ~clr) | hit);
    end
  end

endmodule // gpps_port_irq

// File: dv/gpps_checker.sv
// Checker: port assertions for the pin subsystem
`timescale 1ns/1ps
module gpps_checker
  import gpps_pkg::*;
#(
  parameter int NPINS = GPPS_NUM_PINS,
  parameter int NSRC = 8
) (
  input wire logic clock, // Clock
  input wire logic nrst, // Reset
  input wire logic out_we, // Output write
  input wire logic [NPINS-1:0] out_data, // Output data
  input wire logic [NPINS-1:0] irq_clr, // Flag clears
  input wire logic [NPINS-1:0] fixed_en, // Fixed ownership
  input wire logic wake_rst, // Wake by reset
  input wire logic unfreeze, // Release hold
  input wire logic [NPINS-1:0] pad_in, // Pin levels
  input wire gpps_pad_type [NPINS-1:0] pad_ctl, // Pad controls
  input wire logic [NPINS-1:0] out_reg, // Output register
  input wire logic [NPINS-1:0] pin_state, // Pin state
  input wire logic [NPINS-1:0] periph_in, // Peripheral input
  input wire logic [NPINS-1:0] irq_flags, // Flags
  input wire logic [GPPS_NUM_PORTS-1:0] port_irq, // Port requests
  input wire logic frozen // Hold active
);
  logic [NPINS-1:0] in_en_v;
  always_comb begin
    for (int i = 0; i < NPINS; i++) in_en_v[i] = pad_ctl[i].in_en;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Write followed by three quiet cycles
  sequence s_out_write;
    out_we ##1 (!out_we) [*3];
  endsequence
  a_reset_pads_off: assert property (disable iff (1'b0) !nrst |=> pad_ctl == '0)
    else $error("pads not off during reset");
  a_reset_regs_clear: assert property (disable iff (1'b0) !nrst |=>
    out_reg == '0 && irq_flags == '0 && port_irq == '0 && !frozen) else $error("state not cleared by reset");
  a_port_irq_or: assert property (port_irq == {|irq_flags[18:16], |irq_flags[15:8], |irq_flags[7:0]})
    else $error("port request not the or of its flags");
  a_flag_sticky: assert property ((irq_flags & ~irq_clr) != '0 |=>
    (($past(irq_flags) & ~$past(irq_clr) & ~irq_flags) == '0)) else $error("flag dropped without clear");
  a_out_reg_load: assert property (s_out_write |-> out_reg == $past(out_data, 3))
    else $error("output register missed write");
  a_pin_state_track: assert property (($stable(pad_in) && $stable(in_en_v) && !frozen) [*3] |->
    pin_state == (pad_in & in_en_v)) else $error("pin state wrong");
  a_wake_rst_hiz: assert property (frozen && wake_rst |-> ##[1:2] pad_ctl == '0)
    else $error("pads not released on reset wake");
  a_hold_stable: assert property ((frozen && !wake_rst && !unfreeze) [*3] |=> (!frozen || $stable(pad_ctl)))
    else $error("pads moved while held");
  a_fixed_no_periph: assert property ($stable(fixed_en) [*3] |-> (periph_in & fixed_en) == '0)
    else $error("fixed pin reached matrix");
endmodule // gpps_checker
bind gpps_top gpps_checker #(.NPINS(NPINS), .NSRC(NSRC)) gpps_checker_inst (.clock(clock), .nrst(nrst),
  .out_we(out_we), .out_data(out_data), .irq_clr(irq_clr), .fixed_en(fixed_en), .wake_rst(wake_rst),
  .unfreeze(unfreeze), .pad_in(pad_in), .pad_ctl(pad_ctl), .out_reg(out_reg), .pin_state(pin_state),
  .periph_in(periph_in), .irq_flags(irq_flags), .port_irq(port_irq), .frozen(frozen));

// File: dv/gpps_pad_model.sv
// Partner model: external circuits on the pins
`timescale 1ns/1ps
module gpps_pad_model
  import gpps_pkg::*;
#(
  parameter int NPINS = GPPS_NUM_PINS
) (
  input wire logic clock, // Clock for floating pattern
  input wire gpps_pad_type [NPINS-1:0] pad_ctl, // Device controls
  input wire logic [NPINS-1:0] ext_en, // External driver on
  input wire logic [NPINS-1:0] ext_val, // External level
  output logic [NPINS-1:0] pad_in // Resolved level
);
  logic float_r = 1'b0;
  always @(posedge clock) begin
    float_r <= ~float_r;
  end
  // Strong device drive beats the external source, which beats weak pulls
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (pad_ctl[i].strong_up || pad_ctl[i].strong_dn) pad_in[i] = pad_ctl[i].strong_up;
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_ctl[i].weak_up || pad_ctl[i].weak_dn) pad_in[i] = pad_ctl[i].weak_up;
      else pad_in[i] = float_r ^ i[0];
    end
  end
endmodule // gpps_pad_model

// File: dv/tb_top.sv
// Testbench: self-checking bench for the pin subsystem
`timescale 1ns/1ps
module tb_top;
  import gpps_pkg::*;
  logic clock, nrst, cfg_we, out_we, sleep_req, sleep_retain, wake_irq, wake_rst, unfreeze, frozen, hz;
  logic [1:0] cfg_port;
  logic [7:0] cfg_pin_mask;
  gpps_cfg_type cfg_data;
  logic [18:0] out_data, irq_clr, fixed_en, fixed_out, pad_in, out_reg, pin_state, periph_in, irq_flags;
  logic [18:0] ext_en, ext_val;
  logic [151:0] periph_out;
  gpps_pad_type [18:0] pad_ctl;
  logic [2:0] port_irq;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // Rows: mode, data, expected {strong_up, strong_dn, weak_up, weak_dn}
  localparam logic [7:0] ROWS [16] = '{8'h00, 8'h10, 8'h24, 8'h32, 8'h41, 8'h58, 8'h64, 8'h70,
    8'h80, 8'h98, 8'hA4, 8'hB8, 8'hC0, 8'hD0, 8'hE1, 8'hF2};
  gpps_top gpps_top_inst (.clock(clock), .nrst(nrst), .cfg_we(cfg_we), .cfg_port(cfg_port),
    .cfg_pin_mask(cfg_pin_mask), .cfg_data(cfg_data), .out_we(out_we), .out_data(out_data), .irq_clr(irq_clr),
    .periph_out(periph_out), .fixed_en(fixed_en), .fixed_out(fixed_out), .sleep_req(sleep_req),
    .sleep_retain(sleep_retain), .wake_irq(wake_irq), .wake_rst(wake_rst), .unfreeze(unfreeze),
    .pad_in(pad_in), .pad_ctl(pad_ctl), .out_reg(out_reg), .pin_state(pin_state), .periph_in(periph_in),
    .irq_flags(irq_flags), .port_irq(port_irq), .frozen(frozen));
  gpps_pad_model gpps_pad_model_inst (.clock(clock), .pad_ctl(pad_ctl), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Flags are {vtrip, slew, in_dis, out_dis}
  task automatic cfg(input logic [1:0] p, input logic [7:0] m, input logic [2:0] md, input logic [3:0] f,
    input logic [1:0] e, input logic [2:0] s);
    cfg_port = p;
    cfg_pin_mask = m;
    cfg_data = {md, f, e, s};
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
    cyc(3);
  endtask
  task automatic wr(input logic [18:0] d);
    out_data = d;
    out_we = 1'b1;
    cyc(1);
    out_we = 1'b0;
    cyc(3);
  endtask
  // Pulse order is {sleep_req, wake_irq, wake_rst, unfreeze}
  task automatic pulse(input logic [3:0] v);
    {sleep_req, wake_irq, wake_rst, unfreeze} = v;
    cyc(1);
    {sleep_req, wake_irq, wake_rst, unfreeze} = 4'h0;
    cyc(3);
  endtask
  task automatic clr9();
    irq_clr[9] = 1'b1;
    cyc(1);
    irq_clr[9] = 1'b0;
    cyc(1);
  endtask
  function automatic logic [18:0] su_vec();
    for (int i = 0; i < 19; i++) su_vec[i] = pad_ctl[i].strong_up;
  endfunction
  task automatic conclude();
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {nrst, cfg_we, out_we, sleep_req, sleep_retain, wake_irq, wake_rst, unfreeze} = 8'h00;
    {cfg_port, cfg_pin_mask, cfg_data, out_data, irq_clr, fixed_en, fixed_out, periph_out} = '0;
    ext_en = '1;
    ext_val = '0;
    cyc(4);
    nrst = 1'b1;
    chk("pads after reset", 1, pad_ctl === '0);
    for (int i = 0; i < 16; i++) begin
      cfg(0, 8'h01, ROWS[i][7:5], 4'h0, 2'h0, 3'h0);
      wr({18'h0_0000, ROWS[i][4]});
      chk("drive", ROWS[i][3:0], {pad_ctl[0].strong_up, pad_ctl[0].strong_dn, pad_ctl[0].weak_up, pad_ctl[0].weak_dn});
    end
    cfg(0, 8'h01, 3'h5, 4'hE, 2'h0, 3'h0);
    chk("pad0 in_dis", 7'h43, pad_ctl[0]);
    chk("pin_state in_dis", 0, pin_state[0]);
    cfg(0, 8'h01, 3'h5, 4'h1, 2'h0, 3'h0);
    chk("pad0 out_dis", 7'h04, pad_ctl[0]);
    ext_val[0] = 1'b1;
    cyc(3);
    chk("pin_state", 1, pin_state[0]);
    wr(19'h5_A5A5);
    chk("out_reg", 19'h5_A5A5, out_reg);
    cfg(0, 8'h02, 3'h5, 4'h0, 2'h0, 3'h3);
    periph_out[11] = 1'b1;
    cyc(3);
    chk("matrix drive", 1, pad_ctl[1].strong_up);
    chk("matrix input", 1, periph_in[1]);
    periph_out[11] = 1'b0;
    fixed_en[1] = 1'b1;
    fixed_out[1] = 1'b1;
    cyc(3);
    chk("fixed drive", 1, pad_ctl[1].strong_up);
    chk("fixed input", 0, periph_in[1]);
    fixed_en[1] = 1'b0;
    for (int e = 0; e < 4; e++) begin
      cfg(1, 8'h02, 3'h0, 4'h0, e[1:0], 3'h0);
      clr9();
      ext_val[9] = 1'b1;
      cyc(4);
      chk("rise flag", e[0], irq_flags[9]);
      chk("port irq", {e[0], 1'b0}, port_irq);
      ext_val[9] = 1'b0;
      cyc(4);
      chk("fall flag", e[0] | e[1], irq_flags[9]);
    end
    clr9();
    cyc(1);
    chk("cleared", 0, {irq_flags[9], port_irq});
    cfg(0, 8'h01, 3'h5, 4'h0, 2'h0, 3'h0);
    pulse(4'h8);
    chk("awake run", 2'b01, {frozen, pad_ctl[0].strong_up});
    pulse(4'h4);
    sleep_retain = 1'b1;
    pulse(4'h8);
    cfg(0, 8'h01, 3'h6, 4'h0, 2'h0, 3'h0);
    chk("held", 2'b11, {frozen, pad_ctl[0].strong_up});
    pulse(4'h4);
    chk("irq wake held", 2'b11, {frozen, pad_ctl[0].strong_up});
    pulse(4'h1);
    chk("unfrozen", 2'b00, {frozen, pad_ctl[0].strong_up});
    cfg(0, 8'h01, 3'h5, 4'h0, 2'h0, 3'h0);
    pulse(4'h8);
    wake_rst = 1'b1;
    cyc(1);
    wake_rst = 1'b0;
    hz = (pad_ctl === '0);
    cyc(1);
    hz = hz | (pad_ctl === '0);
    chk("reset wake hiz", 1, hz);
    cyc(3);
    chk("reset wake frozen", 0, frozen);
    wr(19'h7_FFFF);
    for (int p = 0; p < 3; p++) cfg(p[1:0], 8'hFF, 3'h5, 4'h0, 2'h0, 3'h0);
    cfg(1, 8'hFF, 3'h6, 4'h0, 2'h0, 3'h0);
    chk("per port", 19'h7_00FF, su_vec());
    nrst = 1'b0;
    cyc(2);
    chk("pads in reset", 1, pad_ctl === '0);
    chk("out_reg in reset", 0, out_reg);
    nrst = 1'b1;
    cyc(2);
    chk("pads after release", 1, pad_ctl === '0);
    conclude();
  end
endmodule // tb_top
